//--- core/aotf_regs.sv
// Purpose: output test and format register bank for a dual converter
// Assumes: serial port front end delivers byte writes and reads
// Notes: writes other than channel index land in shadow copies, transfer moves them active
`timescale 1ns/1ps
`include "aotf_cfg.svh"
module aotf_regs
   import aotf_pkg::*;
#(
   parameter int W = 11
) (
   input  wire logic          i_clk,
   input  wire logic          i_srst,
   input  wire logic          i_wr,
   input  wire logic          i_rd,
   input  wire logic [7:0]    i_addr,
   input  wire logic [7:0]    i_wdata,
   output logic [7:0]         o_rdata,
   input  wire logic [W-1:0]  i_sample_a,
   input  wire logic [W-1:0]  i_sample_b,
   input  wire logic [15:0]   i_user_pat,
   output logic [W-1:0]       o_data_a,
   output logic [W-1:0]       o_data_b,
   output logic               o_data_oe_a,
   output logic               o_data_oe_b,
   output logic [3:0]         o_drive_code,
   output logic               o_odd_even_en
);
   logic [7:0]   idx_q, idx_d;
   aotf_local_t  sh_q [2], sh_d [2];
   aotf_local_t  act_q [2], act_d [2];
   aotf_global_t gsh_q, gsh_d, gact_q, gact_d;
   logic [7:0]   rdata_q, rdata_d;
   logic [0:0]   rsel;
   logic         xfer;
   logic [W-1:0] samp_w [2];
   logic [W-1:0] data_w [2];
   logic         oe_w   [2];

   always_comb begin
      idx_d   = idx_q;
      gsh_d   = gsh_q;
      sh_d    = sh_q;
      act_d   = act_q;
      gact_d  = gact_q;
      xfer    = i_wr && (i_addr == `AOTF_ADDR_TRANSFER) && i_wdata[`AOTF_XFER_BIT];
      rsel    = idx_q[0] ? 1'b0 : 1'b1;
      rdata_d = rdata_q;
      if (i_wr) begin
         case (i_addr)
            `AOTF_ADDR_CHAN_INDEX: idx_d = {6'h00, i_wdata[1:0]};
            `AOTF_ADDR_DRIVE: begin
               // reserved codes are held off
               if (i_wdata[3:0] <= `AOTF_DRIVE_MAX) begin
                  gsh_d.drive = {4'h0, i_wdata[3:0]};
               end
            end
            `AOTF_ADDR_CLK_PHASE: gsh_d.phase = i_wdata & 8'ha0;
            default: ;
         endcase
         for (int c = 0; c < 2; c++) begin
            if (idx_q[c]) begin
               case (i_addr)
                  `AOTF_ADDR_TEST:   sh_d[c].test   = i_wdata & 8'hbf;
                  `AOTF_ADDR_OFFSET: sh_d[c].offset = i_wdata & 8'h3f;
                  `AOTF_ADDR_FORMAT: sh_d[c].format = i_wdata & 8'h17;
                  default: ;
               endcase
            end
         end
      end
      if (xfer) begin
         act_d  = sh_d;
         gact_d = gsh_d;
      end
      if (i_rd) begin
         case (i_addr)
            `AOTF_ADDR_CHAN_INDEX: rdata_d = idx_q;
            `AOTF_ADDR_TEST:       rdata_d = sh_q[rsel].test;
            `AOTF_ADDR_OFFSET:     rdata_d = sh_q[rsel].offset;
            `AOTF_ADDR_FORMAT:     rdata_d = sh_q[rsel].format;
            `AOTF_ADDR_DRIVE:      rdata_d = gsh_q.drive;
            `AOTF_ADDR_CLK_PHASE:  rdata_d = gsh_q.phase;
            default:               rdata_d = 8'h00;
         endcase
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         idx_q   <= `AOTF_RST_CHAN_INDEX;
         for (int c = 0; c < 2; c++) begin
            sh_q[c]  <= '{`AOTF_RST_TEST, `AOTF_RST_OFFSET, `AOTF_RST_FORMAT};
            act_q[c] <= '{`AOTF_RST_TEST, `AOTF_RST_OFFSET, `AOTF_RST_FORMAT};
         end
         gsh_q   <= '{`AOTF_RST_DRIVE, `AOTF_RST_CLK_PHASE};
         gact_q  <= '{`AOTF_RST_DRIVE, `AOTF_RST_CLK_PHASE};
         rdata_q <= 8'h00;
      end else begin
         idx_q   <= idx_d;
         sh_q    <= sh_d;
         act_q   <= act_d;
         gsh_q   <= gsh_d;
         gact_q  <= gact_d;
         rdata_q <= rdata_d;
      end
   end

   assign samp_w[0] = i_sample_a;
   assign samp_w[1] = i_sample_b;

   // one output path per converter channel
   for (genvar c = 0; c < 2; c++) begin : g_chan
      aotf_chan #(.W(W)) u_chan (
         .i_clk      (i_clk),
         .i_srst     (i_srst),
         .i_cfg      (act_q[c]),
         .i_sample   (samp_w[c]),
         .i_user_pat (i_user_pat),
         .o_data     (data_w[c]),
         .o_data_oe  (oe_w[c])
      );
   end

   assign o_data_a      = data_w[0];
   assign o_data_b      = data_w[1];
   assign o_data_oe_a   = oe_w[0];
   assign o_data_oe_b   = oe_w[1];
   assign o_rdata       = rdata_q;
   assign o_drive_code  = gact_q.drive[3:0];
   assign o_odd_even_en = gact_q.phase[`AOTF_PHASE_ODDEVEN];
endmodule // aotf_regs

//--- core/aotf_cfg.svh
// Purpose: constants for the output test and format register bank
// Assumes: 8-bit register file, byte addresses as printed
// Notes: included by bare name
`ifndef AOTF_CFG_SVH
`define AOTF_CFG_SVH
`define AOTF_ADDR_CHAN_INDEX  8'h05
`define AOTF_ADDR_TEST        8'h0d
`define AOTF_ADDR_OFFSET      8'h10
`define AOTF_ADDR_FORMAT      8'h14
`define AOTF_ADDR_DRIVE       8'h15
`define AOTF_ADDR_CLK_PHASE   8'h16
`define AOTF_ADDR_TRANSFER    8'hff
`define AOTF_RST_CHAN_INDEX   8'h03
`define AOTF_RST_TEST         8'h00
`define AOTF_RST_OFFSET       8'h00
`define AOTF_RST_FORMAT       8'h01
`define AOTF_RST_DRIVE        8'h01
`define AOTF_RST_CLK_PHASE    8'h00
`define AOTF_TEST_REPEAT_BIT  7
`define AOTF_TEST_RST_LONG    5
`define AOTF_TEST_RST_SHORT   4
`define AOTF_FMT_DISABLE_BIT  4
`define AOTF_FMT_INVERT_BIT   2
`define AOTF_PHASE_ODDEVEN    5
`define AOTF_XFER_BIT         0
`define AOTF_PATTERN_LEN      4
`define AOTF_DRIVE_MAX        4'h7
`endif

//--- core/aotf_pkg.sv
// Purpose: types for the output test and format register bank
// Assumes: two converter channels
// Notes: none
package aotf_pkg;
   typedef enum logic [3:0] {
      AOTF_TM_OFF       = 4'h0,
      AOTF_TM_MID       = 4'h1,
      AOTF_TM_POS_FS    = 4'h2,
      AOTF_TM_NEG_FS    = 4'h3,
      AOTF_TM_CHECKER   = 4'h4,
      AOTF_TM_PN_LONG   = 4'h5,
      AOTF_TM_PN_SHORT  = 4'h6,
      AOTF_TM_TOGGLE    = 4'h7,
      AOTF_TM_USER      = 4'h8,
      AOTF_TM_RAMP      = 4'hf
   } aotf_test_mode_t;
   typedef enum logic [1:0] {
      AOTF_FMT_OFFSET_BIN = 2'b00,
      AOTF_FMT_TWOS       = 2'b01,
      AOTF_FMT_GRAY       = 2'b10,
      AOTF_FMT_RSVD       = 2'b11
   } aotf_format_t;
   typedef struct packed {
      logic [7:0] test;
      logic [7:0] offset;
      logic [7:0] format;
   } aotf_local_t;
   typedef struct packed {
      logic [7:0] drive;
      logic [7:0] phase;
   } aotf_global_t;
endpackage

//--- core/aotf_chan.sv
// Purpose: one channel's output path: test data, offset, format, disable
// Assumes: samples in two's complement, active settings stable
// Notes: pattern generators are simple lfsrs and counters
`timescale 1ns/1ps
module aotf_chan
   import aotf_pkg::*;
#(
   parameter int W = 11
) (
   input  wire logic        i_clk,
   input  wire logic        i_srst,
   input  wire aotf_local_t i_cfg,
   input  wire logic [W-1:0] i_sample,
   input  wire logic [15:0] i_user_pat,
   output logic [W-1:0]     o_data,
   output logic             o_data_oe
);
   logic [W-1:0] ramp_q, ramp_d;
   logic [22:0]  pnl_q, pnl_d;
   logic [8:0]   pns_q, pns_d;
   logic         tog_q, tog_d;
   logic [2:0]   cnt_q, cnt_d;
   logic [W-1:0] data_q, data_d;
   logic         oe_q, oe_d;
   logic [W-1:0] sel, adj;
   logic [5:0]   trim;
   aotf_test_mode_t mode;

   always_comb begin
      mode   = aotf_test_mode_t'(i_cfg.test[3:0]);
      trim   = i_cfg.offset[5:0];
      ramp_d = ramp_q + {{(W-1){1'b0}}, 1'b1};
      tog_d  = ~tog_q;
      pnl_d  = i_cfg.test[`AOTF_TEST_RST_LONG] ? 23'h7fffff : {pnl_q[21:0], pnl_q[22] ^ pnl_q[17]};
      pns_d  = i_cfg.test[`AOTF_TEST_RST_SHORT] ? 9'h1ff : {pns_q[7:0], pns_q[8] ^ pns_q[4]};
      // repeat bit set parks at the top, repeat bit clear wraps
      cnt_d  = (mode != AOTF_TM_USER) ? 3'h0 :
               ((i_cfg.test[`AOTF_TEST_REPEAT_BIT] && cnt_q == 3'h7) ? cnt_q : cnt_q + 3'h1);
      // sign-extended trim added to the sample
      adj    = i_sample + {{(W-6){trim[5]}}, trim};
      case (mode)
         AOTF_TM_OFF:      sel = adj;
         AOTF_TM_MID:      sel = '0;
         AOTF_TM_POS_FS:   sel = {1'b0, {(W-1){1'b1}}};
         AOTF_TM_NEG_FS:   sel = {1'b1, {(W-1){1'b0}}};
         AOTF_TM_CHECKER:  sel = tog_q ? W'({(W/2+1){2'b10}}) : W'({(W/2+1){2'b01}});
         AOTF_TM_PN_LONG:  sel = pnl_q[W-1:0];
         AOTF_TM_PN_SHORT: sel = {{(W-9){pns_q[8]}}, pns_q};
         AOTF_TM_TOGGLE:   sel = tog_q ? '1 : '0;
         AOTF_TM_USER: begin
            // repeat bit set sends zeros after the pattern
            if (i_cfg.test[`AOTF_TEST_REPEAT_BIT] && cnt_q >= 3'(`AOTF_PATTERN_LEN)) begin
               sel = '0;
            end else begin
               sel = cnt_q[0] ? ~i_user_pat[W-1:0] : i_user_pat[W-1:0];
            end
         end
         AOTF_TM_RAMP:     sel = ramp_q;
         default:          sel = adj;
      endcase
      case (aotf_format_t'(i_cfg.format[1:0]))
         AOTF_FMT_OFFSET_BIN: data_d = {~sel[W-1], sel[W-2:0]};
         AOTF_FMT_GRAY:       data_d = {~sel[W-1], sel[W-2:0]} ^ ({~sel[W-1], sel[W-2:0]} >> 1);
         default:             data_d = sel;
      endcase
      if (!i_cfg.format[`AOTF_FMT_INVERT_BIT]) begin
         data_d = ~data_d;
      end
      oe_d = ~i_cfg.format[`AOTF_FMT_DISABLE_BIT];
      if (!oe_d) begin
         data_d = '0;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         ramp_q <= '0;
         pnl_q  <= 23'h7fffff;
         pns_q  <= 9'h1ff;
         tog_q  <= 1'b0;
         cnt_q  <= 3'h0;
         data_q <= '0;
         oe_q   <= 1'b1;
      end else begin
         ramp_q <= ramp_d;
         pnl_q  <= pnl_d;
         pns_q  <= pns_d;
         tog_q  <= tog_d;
         cnt_q  <= cnt_d;
         data_q <= data_d;
         oe_q   <= oe_d;
      end
   end

   assign o_data    = data_q;
   assign o_data_oe = oe_q;
endmodule // aotf_chan

//--- dv/aotf_regs_assertions.sv
// Purpose: port checks for the output test and format bank
// Assumes: one clock, synchronous reset
// Notes: bound to aotf_regs
`timescale 1ns/1ps
`include "aotf_cfg.svh"
module aotf_regs_assertions
   import aotf_pkg::*;
#(
   parameter int W = 11
) (
   input wire logic         i_clk,
   input wire logic         i_srst,
   input wire logic         i_wr,
   input wire logic [7:0]   i_addr,
   input wire logic [7:0]   i_wdata,
   input wire logic [W-1:0] o_data_a,
   input wire logic         o_data_oe_a,
   input wire logic         o_data_oe_b,
   input wire logic [3:0]   o_drive_code,
   input wire logic         o_odd_even_en
);
   logic [2:0] h_q;
   logic [2:0] h_d;
   // reset or transfer seen in the last three edges
   always_comb h_d = {h_q[1:0], i_srst | (i_wr & (i_addr == `AOTF_ADDR_TRANSFER) & i_wdata[0])};
   always_ff @(posedge i_clk) h_q <= h_d;
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_srst);
   property p_drv_max; o_drive_code <= `AOTF_DRIVE_MAX; endproperty
   a_drv_max: assert property (p_drv_max) else $error("reserved drive code active");
   property p_drv_rst; $past(i_srst) |-> o_drive_code == 4'h1; endproperty
   a_drv_rst: assert property (p_drv_rst) else $error("drive code reset wrong");
   property p_oe_rst; $past(i_srst) |-> o_data_oe_a && o_data_oe_b; endproperty
   a_oe_rst: assert property (p_oe_rst) else $error("outputs not driven after reset");
   property p_oe_rst2; $past(i_srst) |-> !o_odd_even_en; endproperty
   a_oe_rst2: assert property (p_oe_rst2) else $error("odd even on after reset");
   property p_drv_hold; $changed(o_drive_code) |-> |h_q; endproperty
   a_drv_hold: assert property (p_drv_hold) else $error("drive code moved without transfer");
   property p_oe_hold; $changed(o_odd_even_en) |-> |h_q; endproperty
   a_oe_hold: assert property (p_oe_hold) else $error("odd even moved without transfer");
   property p_off_zero; !o_data_oe_a |-> o_data_a == '0; endproperty
   a_off_zero: assert property (p_off_zero) else $error("disabled channel data not zero");
   property p_dis_a; $changed(o_data_oe_a) |-> |h_q; endproperty
   a_dis_a: assert property (p_dis_a) else $error("channel a enable moved early");
   property p_dis_b; $changed(o_data_oe_b) |-> |h_q; endproperty
   a_dis_b: assert property (p_dis_b) else $error("channel b enable moved early");
endmodule // aotf_regs_assertions
bind aotf_regs aotf_regs_assertions #(.W(W)) i_chk (.i_clk, .i_srst, .i_wr, .i_addr, .i_wdata, .o_data_a,
   .o_data_oe_a, .o_data_oe_b, .o_drive_code, .o_odd_even_en);

//--- dv/aotf_sink.sv
// Purpose: downstream capture of one channel's outputs
// Assumes: capture on rising edge
// Notes: undriven lines read as inverse of last value
`timescale 1ns/1ps
module aotf_sink
   import aotf_pkg::*;
#(
   parameter int W = 11
) (
   input  wire logic         i_clk,
   input  wire logic [W-1:0] i_data,
   input  wire logic         i_oe,
   output logic [W-1:0]      o_cap,
   output logic              o_seen
);
   logic [W-1:0] last_q;
   always_ff @(posedge i_clk) begin
      if (i_oe) begin
         last_q <= i_data;
      end
      o_cap  <= i_oe ? i_data : ~last_q;
      o_seen <= i_oe;
   end
endmodule // aotf_sink

//--- dv/aotf_regs_tb.sv
// Purpose: bench for the output test and format bank
// Assumes: strobes driven at falling edge
// Notes: one sink per channel
`timescale 1ns/1ps
module aotf_regs_tb;
   logic        i_clk = 1'b0, i_srst = 1'b1, i_wr = 1'b0, i_rd = 1'b0, oe_a, oe_b, oddev, seen_a, seen_b;
   logic [7:0]  i_addr = 8'h00, i_wdata = 8'h00, o_rdata;
   logic [10:0] smp = 11'h005, d_a, d_b, cap_a, cap_b;
   logic [3:0]  drv;
   logic [10:0] p0, p1;
   logic [15:0] upat = 16'h0123;
   int          fail_count = 0, cmp_count = 0;
   logic [7:0]  ra [7] = '{8'h05, 8'h0d, 8'h10, 8'h14, 8'h15, 8'h16, 8'h20};
   logic [7:0]  rv [7] = '{8'h03, 8'h00, 8'h00, 8'h01, 8'h01, 8'h00, 8'h00};
   // test, offset, format, expected sample
   logic [34:0] tv [8] = '{{8'h01, 8'h00, 8'h05, 11'h000}, {8'h01, 8'h00, 8'h04, 11'h400},
      {8'h01, 8'h00, 8'h06, 11'h600}, {8'h02, 8'h00, 8'h05, 11'h3ff}, {8'h03, 8'h00, 8'h05, 11'h400},
      {8'h00, 8'h3f, 8'h05, 11'h004}, {8'h00, 8'h1f, 8'h05, 11'h024}, {8'h00, 8'h00, 8'h01, 11'h7fa}};
   always #2.5 i_clk = ~i_clk;
   aotf_regs #(.W(11)) i_dut (.i_clk(i_clk), .i_srst(i_srst), .i_wr(i_wr), .i_rd(i_rd), .i_addr(i_addr),
      .i_wdata(i_wdata), .o_rdata(o_rdata), .i_sample_a(smp), .i_sample_b(smp), .i_user_pat(upat),
      .o_data_a(d_a), .o_data_b(d_b), .o_data_oe_a(oe_a), .o_data_oe_b(oe_b), .o_drive_code(drv),
      .o_odd_even_en(oddev));
   aotf_sink i_sink_a (.i_clk(i_clk), .i_data(d_a), .i_oe(oe_a), .o_cap(cap_a), .o_seen(seen_a));
   aotf_sink i_sink_b (.i_clk(i_clk), .i_data(d_b), .i_oe(oe_b), .o_cap(cap_b), .o_seen(seen_b));
   task automatic chk(input logic [10:0] got, input logic [10:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge i_clk);
      i_wr = 1'b1;
      i_addr = a;
      i_wdata = d;
      @(negedge i_clk);
      i_wr = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(negedge i_clk);
      i_rd = 1'b1;
      i_addr = a;
      @(negedge i_clk);
      i_rd = 1'b0;
      chk(11'(o_rdata), 11'(exp));
   endtask
   task automatic pair(output logic [10:0] a, output logic [10:0] b);
      @(negedge i_clk);
      a = cap_a;
      @(negedge i_clk);
      b = cap_a;
   endtask
   task automatic xfer();
      wr(8'hff, 8'h01);
      repeat (3) @(negedge i_clk);
   endtask
   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      #50000;
      fail_count++;
      finish_test();
   end
   initial begin
      repeat (8) @(negedge i_clk);
      i_srst = 1'b0;
      chk(11'(drv), 11'h001);
      chk(11'(oddev), 11'h000);
      chk(11'({oe_a, oe_b}), 11'h003);
      for (int i = 0; i < 7; i++) rd(ra[i], rv[i]);
      wr(8'h15, 8'h08);
      rd(8'h15, 8'h01);
      wr(8'h15, 8'h07);
      wr(8'h16, 8'h20);
      chk(11'(drv), 11'h001);
      xfer();
      chk(11'(drv), 11'h007);
      chk(11'(oddev), 11'h001);
      wr(8'h05, 8'h01);
      wr(8'h14, 8'h15);
      xfer();
      chk(11'({seen_a, seen_b}), 11'h001);
      chk(d_a, 11'h000);
      rd(8'h14, 8'h15);
      wr(8'h05, 8'h02);
      rd(8'h14, 8'h01);
      wr(8'h14, 8'h15);
      xfer();
      chk(11'({oe_a, oe_b}), 11'h000);
      wr(8'h05, 8'h03);
      for (int i = 0; i < 8; i++) begin
         wr(8'h0d, tv[i][34:27]);
         wr(8'h10, tv[i][26:19]);
         wr(8'h14, tv[i][18:11]);
         xfer();
         chk(cap_a, tv[i][10:0]);
         chk(cap_b, tv[i][10:0]);
      end
      chk(11'(seen_a), 11'h001);
      wr(8'h14, 8'h05);
      wr(8'h0d, 8'h04);
      xfer();
      pair(p0, p1);
      chk(p0 ^ p1, 11'h7ff);
      chk(11'((p0 ^ (p0 >> 1)) & 11'h3ff), 11'h3ff);
      wr(8'h0d, 8'h07);
      xfer();
      pair(p0, p1);
      chk(p0 ^ p1, 11'h7ff);
      chk(11'((p0 ^ (p0 >> 1)) & 11'h3ff), 11'h000);
      wr(8'h0d, 8'h0f);
      xfer();
      pair(p0, p1);
      chk(p1, p0 + 11'h001);
      wr(8'h0d, 8'h16);
      xfer();
      chk(cap_a, 11'h7ff);
      wr(8'h0d, 8'h06);
      xfer();
      pair(p0, p1);
      chk(11'(p0 != p1), 11'h001);
      wr(8'h0d, 8'h25);
      xfer();
      chk(cap_a, 11'h7ff);
      wr(8'h0d, 8'h05);
      xfer();
      pair(p0, p1);
      chk(11'(p0 != p1), 11'h001);
      wr(8'h0d, 8'h08);
      xfer();
      repeat (10) @(negedge i_clk);
      pair(p0, p1);
      chk(p0 ^ p1, 11'h7ff);
      chk(11'(p0 == 11'h123 || p0 == 11'h6dc), 11'h001);
      wr(8'h0d, 8'h88);
      xfer();
      repeat (10) @(negedge i_clk);
      chk(cap_a, 11'h000);
      @(negedge i_clk);
      i_srst = 1'b1;
      repeat (2) @(negedge i_clk);
      i_srst = 1'b0;
      chk(11'(drv), 11'h001);
      chk(11'(oddev), 11'h000);
      rd(8'h0d, 8'h00);
      finish_test();
   end
endmodule // aotf_regs_tb
